// ---- verilog/buck_converter_control_regs.sv ----
// What this block does
// - pin select: follow pins, span 00, ignore registers
// - select clear: registers or operating-point pins
// - span 00: 500-1100 mV, 25 mV steps
// - span 01: 700-1100 mV, 12.5 mV steps
// - span 10: 600-1000 mV, 12.5 mV steps
// - span 11: 500-900 mV, 12.5 mV steps
// - new target reached by successive steps unless step bypass is set
// - slew code selects slew rate
// - mode bit: auto PWM/PFM or forced PWM
// - converter 4 ramp: slow 200 us, fast 60 us
// - reserved bits read zero, ignore writes
// - reset restores defaults, some from OTP
//
// Purpose: control register bank and step sequencer for four step-down converters
// Assumes: register requests come from the serial control front end, one per cycle
// Notes: levels are in 12.5 mV units; analog loop and pin protocol live elsewhere
`timescale 1ns/1ps
module buck_converter_control_regs #(
  parameter int RAMP_SLOW_CYC = buck_ctrl_pkg::RAMP_SLOW_US * buck_ctrl_pkg::CLK_MHZ,
  parameter int RAMP_FAST_CYC = buck_ctrl_pkg::RAMP_FAST_US * buck_ctrl_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // register port
  input wire buck_ctrl_pkg::reg_req_s i_reg_req,
  output logic [7:0] o_reg_rdata_ff,
  // one-time-programmable defaults per converter
  input wire logic [3:0][7:0] i_otp_default,
  // voltage sources
  input wire logic [5:0] i_scale_pin_code,
  input wire logic [3:0] i_op_point_select_pin,
  input wire logic [3:0][7:0] i_op_level,
  input wire logic [3:0][7:0] i_avs_level,
  input wire logic [1:0] i_limit_span,
  input wire logic [3:0] i_step_bypass,
  input wire logic i_conv4_enable,
  // converter controls
  output logic [3:0][7:0] o_level_ff,
  output logic [3:0] o_pwm_force_ff,
  output logic [1:0] o_conv1_span_ff,
  output logic o_conv4_ramp_busy_ff
);
  typedef enum logic [0:0] {RAMP_IDLE, RAMP_RUN} ramp_e;

  typedef struct packed {
    logic [3:0][7:0] regs;
    logic [3:0][7:0] level;
    logic [3:0][buck_ctrl_pkg::STEP_CNT_W-1:0] cnt;
    logic [7:0] rdata;
    logic [1:0] span;
    ramp_e ramp;
    logic [buck_ctrl_pkg::RAMP_CNT_W-1:0] ramp_cnt;
    logic en_prev;
  } state_s;

  state_s st_ff;
  state_s nxt_st;
  logic [3:0][7:0] target;

  always_comb begin
    nxt_st = st_ff;
    target = '0;
    for (int c = 0; c < buck_ctrl_pkg::NUM_CONV; c++) begin
      if (i_reg_req.wr && i_reg_req.addr == buck_ctrl_pkg::REG_ADDR[c]) begin
        nxt_st.regs[c] = i_reg_req.wdata & buck_ctrl_pkg::WR_MASK[c];
      end
    end
    if (i_reg_req.rd) begin
      nxt_st.rdata = buck_ctrl_pkg::RESET_FIXED;
      for (int c = 0; c < buck_ctrl_pkg::NUM_CONV; c++) begin
        if (i_reg_req.addr == buck_ctrl_pkg::REG_ADDR[c]) begin
          nxt_st.rdata = st_ff.regs[c];
        end
      end
    end
    for (int c = 0; c < buck_ctrl_pkg::NUM_CONV; c++) begin
      target[c] = i_op_point_select_pin[c] ? i_avs_level[c] : i_op_level[c];
    end
    nxt_st.span = i_limit_span;
    if (st_ff.regs[0][buck_ctrl_pkg::BIT_PIN_SEL]) begin
      target[0] = buck_ctrl_pkg::pin_level(
        st_ff.regs[0][buck_ctrl_pkg::SPAN_HI:buck_ctrl_pkg::SPAN_LO], i_scale_pin_code);
      nxt_st.span = buck_ctrl_pkg::SPAN_FORCED;
    end
    // one unit per step toward target
    for (int c = 0; c < buck_ctrl_pkg::NUM_CONV; c++) begin
      if (i_step_bypass[c]) begin
        nxt_st.level[c] = target[c];
        nxt_st.cnt[c] = '0;
      end else if (st_ff.level[c] != target[c]) begin
        if (st_ff.cnt[c] == '0) begin
          nxt_st.level[c] = (target[c] > st_ff.level[c]) ? st_ff.level[c] + 8'h01
                                                          : st_ff.level[c] - 8'h01;
          nxt_st.cnt[c] = buck_ctrl_pkg::step_cycles(
            st_ff.regs[c][buck_ctrl_pkg::STEP_HI:buck_ctrl_pkg::STEP_LO]) - 1'b1;
        end else begin
          nxt_st.cnt[c] = st_ff.cnt[c] - 1'b1;
        end
      end else if (st_ff.cnt[c] != '0) begin
        // keep spacing even when the target returns mid-interval
        nxt_st.cnt[c] = st_ff.cnt[c] - 1'b1;
      end
    end
    // start-up ramp window on enable rise
    nxt_st.en_prev = i_conv4_enable;
    unique case (st_ff.ramp)
      RAMP_IDLE: begin
        if (i_conv4_enable && !st_ff.en_prev) begin
          nxt_st.ramp = RAMP_RUN;
          nxt_st.ramp_cnt = st_ff.regs[3][buck_ctrl_pkg::BIT_RAMP]
                          ? buck_ctrl_pkg::RAMP_CNT_W'(RAMP_FAST_CYC - 1)
                          : buck_ctrl_pkg::RAMP_CNT_W'(RAMP_SLOW_CYC - 1);
        end
      end
      RAMP_RUN: begin
        if (!i_conv4_enable || st_ff.ramp_cnt == '0) begin
          nxt_st.ramp = RAMP_IDLE;
          nxt_st.ramp_cnt = '0;
        end else begin
          nxt_st.ramp_cnt = st_ff.ramp_cnt - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      for (int c = 0; c < buck_ctrl_pkg::NUM_CONV; c++) begin
        st_ff.regs[c] <= (i_otp_default[c] & buck_ctrl_pkg::OTP_MASK[c])
                       | (buck_ctrl_pkg::RESET_FIXED & ~buck_ctrl_pkg::OTP_MASK[c]);
      end
      st_ff.level <= '0;
      st_ff.cnt <= '0;
      st_ff.rdata <= '0;
      st_ff.span <= '0;
      st_ff.ramp <= RAMP_IDLE;
      st_ff.ramp_cnt <= '0;
      st_ff.en_prev <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_reg_rdata_ff = st_ff.rdata;
  assign o_level_ff = st_ff.level;
  assign o_conv1_span_ff = st_ff.span;
  assign o_conv4_ramp_busy_ff = (st_ff.ramp == RAMP_RUN);
  for (genvar g = 0; g < buck_ctrl_pkg::NUM_CONV; g++) begin : g_mode
    assign o_pwm_force_ff[g] = st_ff.regs[g][buck_ctrl_pkg::BIT_PWM];
  end

  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  logic pin_sel;
  logic [1:0] pin_span;
  int pc;
  int step_gap;
  assign pin_sel = st_ff.regs[0][buck_ctrl_pkg::BIT_PIN_SEL];
  assign pin_span = st_ff.regs[0][buck_ctrl_pkg::SPAN_HI:buck_ctrl_pkg::SPAN_LO];
  assign pc = int'(i_scale_pin_code);
  always_ff @(posedge i_ref_clk) begin
    // watch converter 2, the one channel whose stepping is exercised
    if (i_sys_rst || i_step_bypass[1] || st_ff.level[1] != nxt_st.level[1]) begin
      step_gap <= 0;
    end else if (step_gap < 1000) begin
      step_gap <= step_gap + 1;
    end
  end

  sequence s_wr2;
    i_reg_req.wr && i_reg_req.addr == buck_ctrl_pkg::ADDR_BUCK2;
  endsequence
  sequence s_rd2;
    i_reg_req.rd && !i_reg_req.wr && i_reg_req.addr == buck_ctrl_pkg::ADDR_BUCK2;
  endsequence

  reserved_zero_a: assert property (st_ff.regs[1][7:5] == 3'h0 && !st_ff.regs[2][0])
    else $error("reserved bit set");
  write_read_a: assert property (s_wr2 ##2 s_rd2 |=> o_reg_rdata_ff ==
    ($past(i_reg_req.wdata, 3) & 8'h1E))
    else $error("readback mismatch");
  pin_span_a: assert property (pin_sel |=> o_conv1_span_ff == 2'h0)
    else $error("span not forced");
  reg_source_a: assert property (!pin_sel |-> target[0] ==
    (i_op_point_select_pin[0] ? i_avs_level[0] : i_op_level[0]))
    else $error("register source wrong");
  span0_a: assert property (pin_sel && pin_span == 2'h0 |->
    int'(target[0]) == 40 + 2 * ((pc > 24) ? 24 : pc))
    else $error("span 00 level wrong");
  span1_a: assert property (pin_sel && pin_span == 2'h1 |->
    int'(target[0]) == 56 + ((pc > 32) ? 32 : pc))
    else $error("span 01 level wrong");
  span2_a: assert property (pin_sel && pin_span == 2'h2 |->
    int'(target[0]) == 48 + ((pc > 32) ? 32 : pc))
    else $error("span 10 level wrong");
  span3_a: assert property (pin_sel && pin_span == 2'h3 |->
    int'(target[0]) == 40 + ((pc > 32) ? 32 : pc))
    else $error("span 11 level wrong");
  single_step_a: assert property (!i_step_bypass[1] |=> (o_level_ff[1] == $past(o_level_ff[1])
    || o_level_ff[1] == $past(o_level_ff[1]) + 8'h01
    || o_level_ff[1] == $past(o_level_ff[1]) - 8'h01))
    else $error("level jumped");
  step_space_a: assert property (!i_step_bypass[1] && $changed(o_level_ff[1])
    && st_ff.regs[1][4:2] == 3'h0 && $stable(st_ff.regs[1][4:2]) && !$past(i_step_bypass[1])
    && $past(step_gap) < 1000 |-> $past(step_gap) >= 40)
    else $error("step too early");
  mode_out_a: assert property (o_pwm_force_ff[3] == st_ff.regs[3][buck_ctrl_pkg::BIT_PWM]
    && o_pwm_force_ff[0] == st_ff.regs[0][buck_ctrl_pkg::BIT_PWM])
    else $error("mode output mismatch");
  ramp_start_a: assert property (i_conv4_enable && !st_ff.en_prev && st_ff.ramp == RAMP_IDLE
    |=> o_conv4_ramp_busy_ff && int'(st_ff.ramp_cnt) == ($past(st_ff.regs[3][0])
    ? RAMP_FAST_CYC - 1 : RAMP_SLOW_CYC - 1))
    else $error("ramp length wrong");
  reset_otp_a: assert property (@(posedge i_ref_clk) i_sys_rst |=>
    st_ff.regs[0] == ($past(i_otp_default[0]) & 8'hE2))
    else $error("reset default wrong");
endmodule

// ---- verilog/buck_ctrl_pkg.sv ----
// Purpose: shared constants and carrier types for the buck converter control bank
// Assumes: 100 MHz reference clock, 8-bit register port
// Notes: output levels are counted in 12.5 mV units from 0 V
package buck_ctrl_pkg;
  localparam int NUM_CONV = 4;
  localparam int CLK_MHZ = 100;
  // register offsets
  localparam logic [7:0] ADDR_BUCK1 = 8'h00;
  localparam logic [7:0] ADDR_BUCK2 = 8'h01;
  localparam logic [7:0] ADDR_BUCK3 = 8'h02;
  localparam logic [7:0] ADDR_BUCK4 = 8'h03;
  localparam logic [3:0][7:0] REG_ADDR = {ADDR_BUCK4, ADDR_BUCK3, ADDR_BUCK2, ADDR_BUCK1};
  // field positions
  localparam int BIT_PIN_SEL = 7;
  localparam int SPAN_HI = 6;
  localparam int SPAN_LO = 5;
  localparam int STEP_HI = 4;
  localparam int STEP_LO = 2;
  localparam int BIT_PWM = 1;
  localparam int BIT_RAMP = 0;
  // writable bits; everything else is reserved
  localparam logic [3:0][7:0] WR_MASK = {8'h1F, 8'h1E, 8'h1E, 8'hFE};
  // bits whose reset value comes from one-time-programmable configuration
  localparam logic [3:0][7:0] OTP_MASK = {8'h03, 8'h02, 8'h02, 8'hE2};
  localparam logic [7:0] RESET_FIXED = 8'h00;
  localparam logic [1:0] SPAN_FORCED = 2'h0;
  // level arithmetic
  localparam int UNIT_UV = 12500;
  localparam int SPAN0_MIN_MV = 500;
  localparam int SPAN0_STEP_UV = 25000;
  localparam int SPAN0_STEPS = 24;
  localparam int SPAN1_MIN_MV = 700;
  localparam int SPAN2_MIN_MV = 600;
  localparam int SPAN3_MIN_MV = 500;
  localparam int FINE_STEP_UV = 12500;
  localparam int FINE_STEPS = 32;
  // slew rate per step code, in hundredths of mV/us
  localparam int SLEW_X100 [8] = '{3000, 1250, 940, 750, 625, 470, 312, 250};
  localparam int STEP_CNT_W = 9;
  // start-up ramp of converter 4
  localparam int RAMP_SLOW_US = 200;
  localparam int RAMP_FAST_US = 60;
  localparam int RAMP_CNT_W = 16;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // level for a pin code; codes past the span top clamp to the top
  function automatic logic [7:0] pin_level(input logic [1:0] span, input logic [5:0] code);
    int base;
    int stp;
    int lim;
    int c;
    base = SPAN0_MIN_MV;
    stp = FINE_STEP_UV;
    lim = FINE_STEPS;
    unique case (span)
      2'h0: begin
        stp = SPAN0_STEP_UV;
        lim = SPAN0_STEPS;
      end
      2'h1: base = SPAN1_MIN_MV;
      2'h2: base = SPAN2_MIN_MV;
      2'h3: base = SPAN3_MIN_MV;
    endcase
    c = (int'(code) > lim) ? lim : int'(code);
    pin_level = 8'((base * 1000 + c * stp) / UNIT_UV);
  endfunction

  // clock cycles between two 12.5 mV steps for a slew code (rounded down)
  function automatic logic [STEP_CNT_W-1:0] step_cycles(input logic [2:0] code);
    step_cycles = STEP_CNT_W'((UNIT_UV * CLK_MHZ) / (SLEW_X100[code] * 10));
  endfunction
endpackage

// ---- verif/buck_host_model.sv ----
// Purpose: host side of the register strobe port
// Assumes: one request per call, launched on a falling edge
// Notes: after release the address and data show the inverse of the last value
`timescale 1ns/1ps
module buck_host_model (
  // clock
  input wire logic i_ref_clk,
  // read data from the bank
  input wire logic [7:0] i_rdata,
  // request to the bank
  output buck_ctrl_pkg::reg_req_s o_req
);
  initial o_req = '0;
  // host read or write transfer
  // callers clear reserved bits except when a refusal is the point
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge i_ref_clk);
    o_req = '{wr: w, rd: ~w, addr: a, wdata: d};
    @(negedge i_ref_clk);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = i_rdata;
  endtask
endmodule

// ---- verif/buck_converter_control_regs_test.sv ----
// Purpose: self-checking bench for the buck converter control bank
// Assumes: ramp counts shortened to 20 and 6 cycles
// Notes: a register mirror in the bench gives the expected readback of the four registers and the pwm force bits
`timescale 1ns/1ps
module buck_converter_control_regs_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] rdata, q, v;
  buck_ctrl_pkg::reg_req_s req;
  logic [3:0][7:0] otp = '0, op_lv = '0, avs_lv = '0, lvl;
  logic [5:0] pin_code = '0;
  logic [3:0] sel_pin = '0, pwm;
  logic [3:0] byp = 4'hD;
  logic [1:0] lim_span = '0, span;
  logic en4 = 1'b0, busy;
  logic [31:0] rs = 32'h3B;
  int err_count = 0;
  int compares = 0;
  int mdl [4];
  int slew [8] = '{3000, 1250, 940, 750, 625, 470, 312, 250};
  int n, b, c;

  buck_host_model host (.i_ref_clk(clk), .i_rdata(rdata), .o_req(req));
  buck_converter_control_regs #(.RAMP_SLOW_CYC(20), .RAMP_FAST_CYC(6)) DUT (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_reg_req(req), .o_reg_rdata_ff(rdata),
    .i_otp_default(otp), .i_scale_pin_code(pin_code), .i_op_point_select_pin(sel_pin),
    .i_op_level(op_lv), .i_avs_level(avs_lv), .i_limit_span(lim_span),
    .i_step_bypass(byp), .i_conv4_enable(en4), .o_level_ff(lvl),
    .o_pwm_force_ff(pwm), .o_conv1_span_ff(span), .o_conv4_ramp_busy_ff(busy));

  initial forever #5 clk = ~clk;

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input int i, input logic [7:0] d);
    host.xfer(1'b1, 8'(i), d, q);
    if (i < 4) mdl[i] = int'(d & buck_ctrl_pkg::WR_MASK[i]);
  endtask

  task automatic rd_chk(input int i);
    host.xfer(1'b0, 8'(i), 8'h00, q);
    check("register", 16'(q), (i < 4) ? 16'(mdl[i]) : 16'h0000);
  endtask

  task automatic wait_lvl();
    n = 0;
    while (lvl[1] === v && n < 600) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic close_out();
    if (err_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #500000;
    err_count++;
    close_out();
  end

  initial begin
    otp = rnd();
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) mdl[i] = int'(otp[i] & buck_ctrl_pkg::OTP_MASK[i]);
    for (int i = 0; i < 4; i++) rd_chk(i);
    for (int i = 0; i < 5; i++) begin
      wr(i, 8'(rnd()));
      rd_chk(i);
    end
    for (int i = 0; i < 4; i++) check("pwm force", 16'(pwm[i]), 16'(mdl[i][1]));
    for (int s = 0; s < 4; s++) begin
      wr(0, 8'h80 | 8'(s << 5));
      pin_code = 6'(rnd());
      lim_span = 2'(rnd());
      b = (s == 1) ? 56 : (s == 2) ? 48 : 40;
      c = (int'(pin_code) > ((s == 0) ? 24 : 32)) ? ((s == 0) ? 24 : 32) : int'(pin_code);
      repeat (3) @(negedge clk);
      check("forced span", 16'(span), 16'h0000);
      check("pin level", 16'(lvl[0]), 16'(b + ((s == 0) ? 2 * c : c)));
    end
    wr(0, 8'h00);
    sel_pin = 4'(rnd()) & 4'hD;
    op_lv = rnd();
    op_lv[1] = 8'h00;
    avs_lv = rnd();
    repeat (3) @(negedge clk);
    check("limit span", 16'(span), 16'(lim_span));
    check("level 1", 16'(lvl[0]), 16'(sel_pin[0] ? avs_lv[0] : op_lv[0]));
    check("level 3", 16'(lvl[2]), 16'(sel_pin[2] ? avs_lv[2] : op_lv[2]));
    check("level 4", 16'(lvl[3]), 16'(sel_pin[3] ? avs_lv[3] : op_lv[3]));
    for (int k = 0; k < 8; k++) begin
      wr(1, 8'(k << 2));
      v = lvl[1];
      op_lv[1] = v + 8'h02;
      wait_lvl();
      check("first step", 16'(lvl[1]), 16'(v + 8'h01));
      v = lvl[1];
      wait_lvl();
      check("step spacing", 16'(n), 16'(1250000 / (slew[k] * 10)));
    end
    for (int f = 0; f < 2; f++) begin
      wr(3, 8'(f));
      en4 = 1'b1;
      n = 0;
      while (busy !== 1'b1 && n < 5) begin
        @(negedge clk);
        n++;
      end
      n = 0;
      while (busy === 1'b1 && n < 40) begin
        @(negedge clk);
        n++;
      end
      check("ramp length", 16'(n), (f == 1) ? 16'h0006 : 16'h0014);
      en4 = 1'b0;
      @(negedge clk);
    end
    close_out();
  end
endmodule
